// ==== hw/field_memory_pkg.sv ====
// Constants shared by the field memory lag model
package field_memory_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 12;
  localparam int DEPTH = 262144;
  // Lag thresholds, in addresses, as the read/write lag classes use them
  localparam logic [17:0] OLD_LAG_LIMIT = 18'h00014;
  localparam logic [17:0] NEW_LAG_LIMIT = 18'h00096;
  localparam logic [17:0] ADDR_RESET = 18'h00000;
  localparam logic [17:0] ADDR_STEP = 18'h00001;
  localparam logic [11:0] DATA_RESET = 12'h000;
  localparam logic [17:0] LAG_RESET = 18'h00000;
endpackage

// ==== hw/pin_sync.sv ====
// Two-stage synchroniser for a pin group with rising-edge pulse on bit 0
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced,
  output logic rise
);
  logic [WIDTH-1:0] stage1;
  logic last0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage1 <= '0;
      synced <= '0;
      last0 <= 1'b0;
    end else begin
      stage1 <= pins;
      synced <= stage1;
      last0 <= synced[0];
    end
  end

  // Only the second stage is looked at
  assign rise = synced[0] & ~last0;
endmodule // pin_sync

// ==== hw/field_memory_lag.sv ====
// Field memory core with lag-dependent old/new/undetermined read behaviour
`timescale 1ns/10ps
module field_memory_lag (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic write_clock,
  input wire logic write_pointer_reset,
  input wire logic [11:0] write_data,
  input wire logic read_clock,
  input wire logic read_pointer_reset,
  output logic [11:0] read_data,
  output logic read_old,
  output logic read_undetermined,
  output logic read_valid,
  output logic [17:0] read_lag
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [13:0] wr_synced;
  logic wr_rise;
  logic [1:0] rd_synced;
  logic rd_rise;

  pin_sync #(.WIDTH(14)) u_wr_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pins({write_data, write_pointer_reset, write_clock}),
    .synced(wr_synced),
    .rise(wr_rise)
  );

  pin_sync #(.WIDTH(2)) u_rd_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pins({read_pointer_reset, read_clock}),
    .synced(rd_synced),
    .rise(rd_rise)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pointers and storage
  // Each word keeps its current and previous value; the previous copy
  // stands in for the line buffering that makes a close reader see old data.
  logic [11:0] mem_cur [field_memory_pkg::DEPTH];
  logic [11:0] mem_prev [field_memory_pkg::DEPTH];
  logic [17:0] wptr;
  logic [17:0] rptr;

  wire [17:0] wr_addr = wr_synced[1] ? field_memory_pkg::ADDR_RESET : wptr;
  wire [11:0] wr_word = wr_synced[13:2];
  wire [17:0] rd_addr = rd_synced[1] ? field_memory_pkg::ADDR_RESET : rptr;
  // Wraps naturally at the power-of-two depth
  wire [17:0] lag = wr_addr - rd_addr;
  wire lag_old = lag < field_memory_pkg::OLD_LAG_LIMIT;
  wire lag_new = lag > field_memory_pkg::NEW_LAG_LIMIT;
  wire lag_undet = !lag_old && !lag_new;
  wire [11:0] rd_word = lag_old ? mem_prev[rd_addr] : mem_cur[rd_addr];

  always_ff @(posedge mclk) begin
    if (wr_rise) begin
      mem_prev[wr_addr] <= mem_cur[wr_addr];
      mem_cur[wr_addr] <= wr_word;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wptr <= field_memory_pkg::ADDR_RESET;
    end else if (wr_rise) begin
      wptr <= 18'(wr_addr + field_memory_pkg::ADDR_STEP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read side
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rptr <= field_memory_pkg::ADDR_RESET;
      read_data <= field_memory_pkg::DATA_RESET;
      read_old <= 1'b0;
      read_undetermined <= 1'b0;
      read_valid <= 1'b0;
      read_lag <= field_memory_pkg::LAG_RESET;
    end else begin
      read_valid <= rd_rise;
      if (rd_rise) begin
        rptr <= 18'(rd_addr + field_memory_pkg::ADDR_STEP);
        read_data <= rd_word;
        read_old <= lag_old;
        read_undetermined <= lag_undet;
        read_lag <= lag;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_new_read;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && (lag > field_memory_pkg::NEW_LAG_LIMIT)) |=> (read_valid && !read_old && !read_undetermined
        && read_data == mem_cur[$past(rd_addr)]);
  endproperty
  a_new_read: assert property (p_new_read) else $error("new data read misclassified");

  property p_old_read;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && (lag < field_memory_pkg::OLD_LAG_LIMIT)) |=> (read_old && !read_undetermined && read_valid);
  endproperty
  a_old_read: assert property (p_old_read) else $error("old data read misclassified");

  property p_undet_read;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && (lag >= field_memory_pkg::OLD_LAG_LIMIT) && (lag <= field_memory_pkg::NEW_LAG_LIMIT))
        |=> (read_undetermined && !read_old);
  endproperty
  a_undet_read: assert property (p_undet_read) else $error("undetermined lag not flagged");

  property p_write_stored;
    @(posedge mclk) disable iff (!rst_n)
      wr_rise |=> (mem_cur[$past(wr_addr)] == $past(wr_word))
        && (wptr == $past(wr_addr) + field_memory_pkg::ADDR_STEP);
  endproperty
  a_write_stored: assert property (p_write_stored) else $error("written word not stored");

  property p_lag_value;
    @(posedge mclk) disable iff (!rst_n)
      rd_rise |=> (read_lag == $past(wptr) - $past(rptr)) || $past(wr_synced[1]) || $past(rd_synced[1]);
  endproperty
  a_lag_value: assert property (p_lag_value) else $error("lag not write minus read");

  property p_hold_between;
    @(posedge mclk) disable iff (!rst_n)
      (!rd_rise ##1 1'b1) |-> (!read_valid && $stable(read_data) && $stable(read_lag));
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("read outputs moved without access");

  // Result handshake: one valid pulse per read access, never stretched
  property p_valid_follows;
    @(posedge mclk) disable iff (!rst_n)
      rd_rise |=> read_valid;
  endproperty
  a_valid_follows: assert property (p_valid_follows) else $error("read access gave no valid pulse");

  property p_valid_pulse;
    @(posedge mclk) disable iff (!rst_n)
      read_valid |=> !read_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid pulse longer than one cycle");

  // Class flags are exclusive and only move on an access
  property p_flags_exclusive;
    @(posedge mclk) disable iff (!rst_n)
      read_valid |-> !(read_old && read_undetermined);
  endproperty
  a_flags_exclusive: assert property (p_flags_exclusive) else $error("old and undetermined both set");

  property p_flags_hold;
    @(posedge mclk) disable iff (!rst_n)
      !rd_rise |=> ($stable(read_old) && $stable(read_undetermined));
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("class flags moved without access");

  property p_lag_class_new;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && lag_new) |=> (read_lag > field_memory_pkg::NEW_LAG_LIMIT);
  endproperty
  a_lag_class_new: assert property (p_lag_class_new) else $error("new read with short lag");

  property p_lag_class_old;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && lag_old) |=> (read_lag < field_memory_pkg::OLD_LAG_LIMIT);
  endproperty
  a_lag_class_old: assert property (p_lag_class_old) else $error("old read with long lag");

  // Undetermined reads still see the stored word, so writes were kept intact
  property p_undet_data;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && lag_undet) |=> (read_data == mem_cur[$past(rd_addr)]);
  endproperty
  a_undet_data: assert property (p_undet_data) else $error("stored word lost in undetermined range");

  // Pointer bookkeeping: a series starts at address zero
  property p_write_series_start;
    @(posedge mclk) disable iff (!rst_n)
      (wr_rise && wr_synced[1]) |=> (wptr == field_memory_pkg::ADDR_STEP);
  endproperty
  a_write_series_start: assert property (p_write_series_start) else $error("write series not at zero");

  property p_read_series_start;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && rd_synced[1]) |=> (rptr == field_memory_pkg::ADDR_STEP);
  endproperty
  a_read_series_start: assert property (p_read_series_start) else $error("read series not at zero");

  property p_read_reset_lag;
    @(posedge mclk) disable iff (!rst_n)
      (rd_rise && rd_synced[1]) |=> (read_lag == $past(wr_addr));
  endproperty
  a_read_reset_lag: assert property (p_read_reset_lag) else $error("lag at read reset wrong");

  property p_rptr_step;
    @(posedge mclk) disable iff (!rst_n)
      rd_rise |=> (rptr == $past(rd_addr) + field_memory_pkg::ADDR_STEP);
  endproperty
  a_rptr_step: assert property (p_rptr_step) else $error("read pointer did not step");

  // Idle pointers must not creep, or every later lag would be off
  property p_wptr_idle;
    @(posedge mclk) disable iff (!rst_n)
      !wr_rise |=> $stable(wptr);
  endproperty
  a_wptr_idle: assert property (p_wptr_idle) else $error("write pointer moved without access");

  property p_rptr_idle;
    @(posedge mclk) disable iff (!rst_n)
      !rd_rise |=> $stable(rptr);
  endproperty
  a_rptr_idle: assert property (p_rptr_idle) else $error("read pointer moved without access");
endmodule // field_memory_lag

// ==== tb/field_memory_driver.sv ====
// Partner model: video logic pulsing the write and read pins
`timescale 1ns/10ps
module field_memory_driver (
  input wire logic mclk,
  output logic write_clock,
  output logic write_pointer_reset,
  output logic [11:0] write_data,
  output logic read_clock,
  output logic read_pointer_reset
);
  initial {write_clock, write_pointer_reset, write_data, read_clock, read_pointer_reset} = '0;
  // Reads never overlap writes, so no lag moves during a read
  task automatic pulse(input logic is_wr, input logic rs, input logic [11:0] d);
    @(posedge mclk) #1;
    if (is_wr) {write_clock, write_pointer_reset, write_data} = {1'b1, rs, d};
    else {read_clock, read_pointer_reset} = {1'b1, rs};
    repeat (3) @(posedge mclk);
    #1 {write_clock, read_clock} = 2'b00;
    repeat (3) @(posedge mclk);
    #1 {write_pointer_reset, read_pointer_reset} = 2'b00;
    // Released data line shows the inverse, not the last word
    write_data = ~d;
  endtask
endmodule // field_memory_driver

// ==== tb/field_memory_read_lag_policy_tb.sv ====
// Self-checking bench for the lag-dependent reads of the field memory
`timescale 1ns/10ps
module field_memory_read_lag_policy_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic got = 1'b0;
  wire write_clock, write_pointer_reset, read_clock, read_pointer_reset;
  wire [11:0] write_data;
  logic [11:0] read_data;
  logic read_old, read_undetermined, read_valid;
  logic [17:0] read_lag;
  int num_errors = 0;
  int compares = 0;
  int cur[int];
  int prev[int];
  int waddr = 0;
  int raddr = 0;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (read_valid === 1'b1) got <= 1'b1;
  field_memory_lag field_memory_lag_i (.mclk(mclk), .rst_n(rst_n), .write_clock(write_clock),
    .write_pointer_reset(write_pointer_reset), .write_data(write_data), .read_clock(read_clock),
    .read_pointer_reset(read_pointer_reset), .read_data(read_data), .read_old(read_old),
    .read_undetermined(read_undetermined), .read_valid(read_valid), .read_lag(read_lag));
  field_memory_driver field_memory_driver_i (.mclk(mclk), .write_clock(write_clock),
    .write_pointer_reset(write_pointer_reset), .write_data(write_data), .read_clock(read_clock),
    .read_pointer_reset(read_pointer_reset));
  task automatic wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] seen);
    compares++;
    if (exp !== seen) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic rs);
    logic [11:0] d;
    d = 12'($urandom);
    if (rs) waddr = 0;
    if (cur.exists(waddr)) prev[waddr] = cur[waddr];
    cur[waddr] = d;
    waddr = (waddr + 1) % field_memory_pkg::DEPTH;
    field_memory_driver_i.pulse(1'b1, rs, d);
  endtask
  task automatic rd(input logic rs);
    int lag;
    int n;
    if (rs) raddr = 0;
    lag = (waddr - raddr + field_memory_pkg::DEPTH) % field_memory_pkg::DEPTH;
    got = 1'b0;
    field_memory_driver_i.pulse(1'b0, rs, 12'h000);
    for (n = 0; n < 20 && got !== 1'b1; n++) @(posedge mclk);
    if (got !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    check("read_lag", 18'(lag), read_lag);
    check("read_valid", 18'h00000, 18'(read_valid));
    check("read_old", 18'(lag < 20), 18'(read_old));
    check("read_undetermined", 18'(lag >= 20 && lag <= 150), 18'(read_undetermined));
    if (lag < 20 && prev.exists(raddr)) check("old data", 18'(prev[raddr]), 18'(read_data));
    if (lag > 150) check("new data", 18'(cur[raddr]), 18'(read_data));
    raddr = (raddr + 1) % field_memory_pkg::DEPTH;
  endtask
  initial begin
    int i;
    void'($urandom(67180));
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (i = 0; i < 200; i++) wr(i == 0);
    for (i = 0; i < 30; i++) rd(i == 0);
    for (i = 0; i < 5; i++) wr(i == 0);
    rd(1'b1);
    // Writes outpace reads, sweeping the lag through all three classes
    for (i = 0; i < 300; i++) begin
      repeat ($urandom_range(3, 1)) wr(1'b0);
      rd(1'b0);
    end
    wrap_up();
  end
endmodule // field_memory_read_lag_policy_tb
